// *** rtl/tpc_pkg.sv ***
package tpc_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int NTHR = 8;
    localparam int TW = 3;
    localparam int NEVT = 8;
    localparam int CW = 32;
    localparam int AW = 4;
    localparam int PAW = 12;

    // ------------------------------------------------------------
    // register map: per-thread block of three words
    // ------------------------------------------------------------
    localparam logic [1:0] REG_CFG = 2'h0;
    localparam logic [1:0] REG_CNT_LO = 2'h1;
    localparam logic [1:0] REG_CNT_HI = 2'h2;
    localparam int ADR_REG_LSB = 2;
    localparam int ADR_THR_LSB = 4;
    localparam int ADR_TOP_LSB = 7;

    // ------------------------------------------------------------
    // count_config_reg fields
    // ------------------------------------------------------------
    localparam int F_SEL_LO = 0;
    localparam int F_SEL_HI = 3;
    localparam int F_SEL_W = 3;
    localparam int F_EN_LO = 6;
    localparam int F_EN_HI = 7;
    localparam int F_TRAP_LO = 8;
    localparam int F_TRAP_HI = 9;
    localparam int F_OVF_LO = 10;
    localparam int F_OVF_HI = 11;
    localparam logic [CW-1:0] CFG_WMASK = 32'h0000_0fff;
    localparam logic [CW-1:0] CFG_RST = 32'h0000_0000;
    localparam logic [CW-1:0] CNT_RST = 32'h0000_0000;
    localparam logic [AW-1:0] ACC_RST = 4'h0;
    localparam logic [TW-1:0] SLOT_STEP = 3'h1;

endpackage

// *** rtl/tpc_ctl.sv ***
`timescale 1ns/1ps
`default_nettype none

module tpc_ctl import tpc_pkg::*; (
    // clock and reset
    input wire logic mclk_i,
    input wire logic arst_n_i,
    // events and register writes
    input wire logic [NTHR*NEVT-1:0] evt_i,
    input wire logic [NTHR-1:0] cfg_wr_i,
    input wire logic [CW-1:0] wdata_i,
    // overflow pulses from datapath
    input wire logic [NTHR-1:0] ovf_lo_i,
    input wire logic [NTHR-1:0] ovf_hi_i,
    // control outputs
    output logic [NTHR*CW-1:0] cfg_o,
    output logic [NTHR-1:0] inc_lo_o,
    output logic [NTHR-1:0] inc_hi_o,
    output logic [NTHR-1:0] trap_o,
    output logic [TW-1:0] slot_o,
    output logic any_en_o
);

    // ------------------------------------------------------------
    // event pick
    // ------------------------------------------------------------
    function automatic logic ev_pick(input logic [CW-1:0] cfg, input logic [NEVT-1:0] ev,
                                     input int sel_lsb, input int en_bit);
        logic [F_SEL_W-1:0] sel;
        sel = cfg[sel_lsb +: F_SEL_W];
        return ev[sel] & cfg[en_bit];
    endfunction

    logic [CW-1:0] cfg_q [NTHR];
    logic [CW-1:0] cfg_d [NTHR];
    logic [TW-1:0] slot_q;
    logic [TW-1:0] slot_d;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        any_en_o = 1'b0;
        for (int t = 0; t < NTHR; t++) begin
            cfg_d[t] = cfg_q[t];
            if (cfg_wr_i[t]) begin
                cfg_d[t] = wdata_i & CFG_WMASK;
            end
            // set wins over a clearing write
            if (ovf_lo_i[t]) begin
                cfg_d[t][F_OVF_LO] = 1'b1;
            end
            if (ovf_hi_i[t]) begin
                cfg_d[t][F_OVF_HI] = 1'b1;
            end
            inc_lo_o[t] = ev_pick(cfg_q[t], evt_i[t*NEVT +: NEVT], F_SEL_LO, F_EN_LO);
            inc_hi_o[t] = ev_pick(cfg_q[t], evt_i[t*NEVT +: NEVT], F_SEL_HI, F_EN_HI);
            trap_o[t] = (cfg_q[t][F_OVF_LO] & cfg_q[t][F_TRAP_LO])
                      | (cfg_q[t][F_OVF_HI] & cfg_q[t][F_TRAP_HI]);
            any_en_o = any_en_o | cfg_q[t][F_EN_LO] | cfg_q[t][F_EN_HI];
            cfg_o[t*CW +: CW] = cfg_q[t];
        end
        slot_d = slot_q + SLOT_STEP;
        slot_o = slot_q;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int t = 0; t < NTHR; t++) begin
                cfg_q[t] <= CFG_RST;
            end
            slot_q <= '0;
        end else begin
            cfg_q <= cfg_d;
            slot_q <= slot_d;
        end
    end

endmodule

`default_nettype wire

// *** rtl/tpc_dp.sv ***
`timescale 1ns/1ps
`default_nettype none

module tpc_dp import tpc_pkg::*; (
    // clock and reset
    input wire logic mclk_i,
    input wire logic arst_n_i,
    // control
    input wire logic [TW-1:0] slot_i,
    input wire logic [NTHR-1:0] inc_lo_i,
    input wire logic [NTHR-1:0] inc_hi_i,
    // counter writes
    input wire logic [NTHR-1:0] lo_wr_i,
    input wire logic [NTHR-1:0] hi_wr_i,
    input wire logic [CW-1:0] wdata_i,
    // state out
    output logic [NTHR*CW-1:0] cnt_lo_o,
    output logic [NTHR*CW-1:0] cnt_hi_o,
    output logic [NTHR*AW-1:0] acc_lo_o,
    output logic [NTHR*AW-1:0] acc_hi_o,
    output logic [NTHR-1:0] ovf_lo_o,
    output logic [NTHR-1:0] ovf_hi_o
);

    // ------------------------------------------------------------
    // shared adder
    // ------------------------------------------------------------
    function automatic logic [CW:0] fold(input logic [CW-1:0] cnt, input logic [AW-1:0] acc);
        return {1'b0, cnt} + {{(CW+1-AW){1'b0}}, acc};
    endfunction

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] acc, input logic inc);
        return acc + {{(AW-1){1'b0}}, inc};
    endfunction

    logic [CW-1:0] lo_q [NTHR];
    logic [CW-1:0] lo_d [NTHR];
    logic [CW-1:0] hi_q [NTHR];
    logic [CW-1:0] hi_d [NTHR];
    logic [AW-1:0] alo_q [NTHR];
    logic [AW-1:0] alo_d [NTHR];
    logic [AW-1:0] ahi_q [NTHR];
    logic [AW-1:0] ahi_d [NTHR];
    logic [CW:0] sum_lo;
    logic [CW:0] sum_hi;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        sum_lo = fold(lo_q[slot_i], alo_q[slot_i]);
        sum_hi = fold(hi_q[slot_i], ahi_q[slot_i]);
        for (int t = 0; t < NTHR; t++) begin
            lo_d[t] = lo_q[t];
            hi_d[t] = hi_q[t];
            alo_d[t] = bump(alo_q[t], inc_lo_i[t]);
            ahi_d[t] = bump(ahi_q[t], inc_hi_i[t]);
            ovf_lo_o[t] = 1'b0;
            ovf_hi_o[t] = 1'b0;
            if (slot_i == TW'(t)) begin
                lo_d[t] = sum_lo[CW-1:0];
                hi_d[t] = sum_hi[CW-1:0];
                alo_d[t] = bump(ACC_RST, inc_lo_i[t]);
                ahi_d[t] = bump(ACC_RST, inc_hi_i[t]);
                ovf_lo_o[t] = sum_lo[CW] & ~lo_wr_i[t];
                ovf_hi_o[t] = sum_hi[CW] & ~hi_wr_i[t];
            end
            if (lo_wr_i[t]) begin
                lo_d[t] = wdata_i;
            end
            if (hi_wr_i[t]) begin
                hi_d[t] = wdata_i;
            end
            cnt_lo_o[t*CW +: CW] = lo_q[t];
            cnt_hi_o[t*CW +: CW] = hi_q[t];
            acc_lo_o[t*AW +: AW] = alo_q[t];
            acc_hi_o[t*AW +: AW] = ahi_q[t];
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int t = 0; t < NTHR; t++) begin
                lo_q[t] <= CNT_RST;
                hi_q[t] <= CNT_RST;
                alo_q[t] <= ACC_RST;
                ahi_q[t] <= ACC_RST;
            end
        end else begin
            lo_q <= lo_d;
            hi_q <= hi_d;
            alo_q <= alo_d;
            ahi_q <= ahi_d;
        end
    end

endmodule

`default_nettype wire

// *** rtl/tpc_top.sv ***
`timescale 1ns/1ps
`default_nettype none

// Operation
// - each thread has its own config register and a high and a low counter
// - two shared 32-bit adders, one for all high, one for all low counters
// - adders go to threads in turn, each thread once every eight cycles
// - each counter has a 4-bit accumulator bumped on every event cycle
// - on its turn a thread's counters get their accumulators added in
// - config selects and enables events, sets overflow bits and requests traps
// - unit wakes on any register access or any enabled counter, else idles
// - split into a control part and a datapath part
module tpc_top import tpc_pkg::*; (
    // clock and reset
    input wire logic mclk_i,
    input wire logic arst_n_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [PAW-1:0] paddr_i,
    input wire logic [CW-1:0] pwdata_i,
    output logic pready_o,
    output logic [CW-1:0] prdata_o,
    output logic pslverr_o,
    // core events, thread t owns bits t*8 .. t*8+7
    input wire logic [NTHR*NEVT-1:0] evt_i,
    // trap logic and clock gate
    output logic [NTHR-1:0] trap_req_o,
    output logic wake_o
);

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    function automatic logic bad_addr(input logic [PAW-1:0] a);
        return (a[PAW-1:ADR_TOP_LSB] != '0) || (a[ADR_REG_LSB +: 2] > REG_CNT_HI)
            || (a[1:0] != 2'h0);
    endfunction

    logic [TW-1:0] a_thr;
    logic [1:0] a_reg;
    logic wr_ok;
    logic [NTHR-1:0] cfg_wr;
    logic [NTHR-1:0] lo_wr;
    logic [NTHR-1:0] hi_wr;
    logic [CW-1:0] prdata_q;
    logic [CW-1:0] prdata_d;

    logic [NTHR*CW-1:0] cfg_flat;
    logic [NTHR*CW-1:0] cnt_lo;
    logic [NTHR*CW-1:0] cnt_hi;
    logic [NTHR*AW-1:0] acc_lo;
    logic [NTHR*AW-1:0] acc_hi;
    logic [NTHR-1:0] inc_lo;
    logic [NTHR-1:0] inc_hi;
    logic [NTHR-1:0] ovf_lo;
    logic [NTHR-1:0] ovf_hi;
    logic [TW-1:0] slot;
    logic any_en;

    always_comb begin
        a_thr = paddr_i[ADR_THR_LSB +: TW];
        a_reg = paddr_i[ADR_REG_LSB +: 2];
        wr_ok = psel_i & penable_i & pwrite_i & ~bad_addr(paddr_i);
        for (int t = 0; t < NTHR; t++) begin
            cfg_wr[t] = wr_ok && (a_thr == TW'(t)) && (a_reg == REG_CFG);
            lo_wr[t] = wr_ok && (a_thr == TW'(t)) && (a_reg == REG_CNT_LO);
            hi_wr[t] = wr_ok && (a_thr == TW'(t)) && (a_reg == REG_CNT_HI);
        end
    end

    // ------------------------------------------------------------
    // read data, captured in the setup cycle
    // ------------------------------------------------------------
    always_comb begin
        prdata_d = prdata_q;
        if (psel_i && !penable_i) begin
            prdata_d = '0;
            if (!bad_addr(paddr_i)) begin
                unique case (a_reg)
                    REG_CFG: prdata_d = cfg_flat[a_thr*CW +: CW];
                    REG_CNT_LO: prdata_d = cnt_lo[a_thr*CW +: CW];
                    REG_CNT_HI: prdata_d = cnt_hi[a_thr*CW +: CW];
                    default: prdata_d = '0;
                endcase
            end
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prdata_q <= '0;
        end else begin
            prdata_q <= prdata_d;
        end
    end

    assign pready_o = 1'b1;
    assign prdata_o = prdata_q;
    assign pslverr_o = psel_i & penable_i & bad_addr(paddr_i);

    // ------------------------------------------------------------
    // clock gate request
    // ------------------------------------------------------------
    assign wake_o = psel_i | any_en;

    // ------------------------------------------------------------
    // control and datapath
    // ------------------------------------------------------------
    tpc_ctl u_ctl (
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .evt_i(evt_i),
        .cfg_wr_i(cfg_wr),
        .wdata_i(pwdata_i),
        .ovf_lo_i(ovf_lo),
        .ovf_hi_i(ovf_hi),
        .cfg_o(cfg_flat),
        .inc_lo_o(inc_lo),
        .inc_hi_o(inc_hi),
        .trap_o(trap_req_o),
        .slot_o(slot),
        .any_en_o(any_en)
    );

    tpc_dp u_dp (
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .slot_i(slot),
        .inc_lo_i(inc_lo),
        .inc_hi_i(inc_hi),
        .lo_wr_i(lo_wr),
        .hi_wr_i(hi_wr),
        .wdata_i(pwdata_i),
        .cnt_lo_o(cnt_lo),
        .cnt_hi_o(cnt_hi),
        .acc_lo_o(acc_lo),
        .acc_hi_o(acc_hi),
        .ovf_lo_o(ovf_lo),
        .ovf_hi_o(ovf_hi)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [CW-1:0] c0_lo;
    logic [CW-1:0] c0_hi;
    logic [CW-1:0] cfg0;
    logic [AW-1:0] a0_lo;
    logic [AW-1:0] a0_hi;
    logic any_cfg;
    logic [CW:0] sum0_lo;
    logic [CW:0] sum0_hi;
    logic cy0_lo;
    logic cy0_hi;

    assign c0_lo = cnt_lo[CW-1:0];
    assign c0_hi = cnt_hi[CW-1:0];
    assign cfg0 = cfg_flat[CW-1:0];
    assign a0_lo = acc_lo[AW-1:0];
    assign a0_hi = acc_hi[AW-1:0];
    assign any_cfg = |cfg_flat;
    assign sum0_lo = {1'b0, c0_lo} + {{(CW+1-AW){1'b0}}, a0_lo};
    assign sum0_hi = {1'b0, c0_hi} + {{(CW+1-AW){1'b0}}, a0_hi};
    assign cy0_lo = (slot == 3'h0) && !lo_wr[0] && sum0_lo[CW];
    assign cy0_hi = (slot == 3'h0) && !hi_wr[0] && sum0_hi[CW];

    a_slot_turn: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        slot == 3'h0 |=> (slot != 3'h0) [*7] ##1 slot == 3'h0)
        else $error("thread 0 not revisited after eight cycles");

    a_acc_count: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        slot != 3'h0 |=> a0_lo == $past(a0_lo) + 4'($past(inc_lo[0])))
        else $error("low accumulator missed an event");

    a_acc_restart: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        slot == 3'h0 |=> a0_hi == 4'($past(inc_hi[0])))
        else $error("high accumulator did not restart after fold");

    a_fold_sum: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        slot == 3'h0 && !lo_wr[0] |=> c0_lo == $past(c0_lo) + 32'($past(a0_lo)))
        else $error("low counter fold sum wrong");

    a_hold_off: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        slot != 3'h0 && !hi_wr[0] |=> c0_hi == $past(c0_hi))
        else $error("high counter changed outside its slot");

    a_wrap_ovf: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        slot == 3'h0 && c0_lo == 32'hffff_ffff && a0_lo != 4'h0 && !lo_wr[0]
        |=> cfg0[F_OVF_LO] && c0_lo == 32'($past(a0_lo)) - 32'h1)
        else $error("wrap did not set overflow");

    a_trap_req: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        ovf_hi[0] && cfg0[F_TRAP_HI] && !cfg_wr[0] ##1 !cfg_wr[0]
        |-> trap_req_o[0] ##1 trap_req_o[0])
        else $error("overflow with trap enable gave no trap request");

    a_cfg_keep: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        cfg_wr[0] && !ovf_lo[0] && !ovf_hi[0] |=> cfg0 == ($past(pwdata_i) & CFG_WMASK))
        else $error("config write not stored");

    a_wake_idle: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        !psel_i && !any_cfg |-> !wake_o)
        else $error("unit awake while idle");

    a_wake_busy: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        psel_i |-> wake_o)
        else $error("register access without wake");

    a_wake_en: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        any_en |-> wake_o)
        else $error("enabled counter without wake");

    a_slot_step: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        1'b1 |=> slot == 3'($past(slot) + 3'h1))
        else $error("slot did not advance by one");

    a_acc_hi_count: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        slot != 3'h0 |=> a0_hi == $past(a0_hi) + 4'($past(inc_hi[0])))
        else $error("high accumulator missed an event");

    a_acc_lo_restart: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        slot == 3'h0 |=> a0_lo == 4'($past(inc_lo[0])))
        else $error("low accumulator did not restart after fold");

    a_fold_hi_sum: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        slot == 3'h0 && !hi_wr[0] |=> c0_hi == $past(c0_hi) + 32'($past(a0_hi)))
        else $error("high counter fold sum wrong");

    a_hold_lo: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        slot != 3'h0 && !lo_wr[0] |=> c0_lo == $past(c0_lo))
        else $error("low counter changed outside its slot");

    a_carry_lo: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        cy0_lo |=> cfg0[F_OVF_LO])
        else $error("low carry did not set overflow");

    a_carry_hi: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        cy0_hi |=> cfg0[F_OVF_HI])
        else $error("high carry did not set overflow");

    a_no_ovf_lo: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        !cfg0[F_OVF_LO] && !cfg_wr[0] && !cy0_lo |=> !cfg0[F_OVF_LO])
        else $error("low overflow set without carry");

    a_no_ovf_hi: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        !cfg0[F_OVF_HI] && !cfg_wr[0] && !cy0_hi |=> !cfg0[F_OVF_HI])
        else $error("high overflow set without carry");

    a_sticky_lo: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        cfg0[F_OVF_LO] && !cfg_wr[0] |=> cfg0[F_OVF_LO])
        else $error("low overflow bit lost");

    a_sticky_hi: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        cfg0[F_OVF_HI] && !cfg_wr[0] |=> cfg0[F_OVF_HI])
        else $error("high overflow bit lost");

    a_trap_lo: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        cfg0[F_OVF_LO] && cfg0[F_TRAP_LO] |-> trap_req_o[0])
        else $error("low overflow with trap enable gave no trap");

    a_trap_hi: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        cfg0[F_OVF_HI] && cfg0[F_TRAP_HI] |-> trap_req_o[0])
        else $error("high overflow with trap enable gave no trap");

    a_no_trap: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        !(cfg0[F_OVF_LO] && cfg0[F_TRAP_LO]) && !(cfg0[F_OVF_HI] && cfg0[F_TRAP_HI])
        |-> !trap_req_o[0])
        else $error("trap request without enabled overflow");

    a_cfg_mask: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (cfg0 & ~CFG_WMASK) == 32'h0)
        else $error("unused config bits not zero");

    a_inc_gate_lo: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        !cfg0[F_EN_LO] |-> !inc_lo[0])
        else $error("disabled low counter counts");

    a_inc_gate_hi: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        !cfg0[F_EN_HI] |-> !inc_hi[0])
        else $error("disabled high counter counts");

    a_inc_sel_lo: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        cfg0[F_EN_LO] |-> inc_lo[0] == evt_i[cfg0[F_SEL_LO +: F_SEL_W]])
        else $error("low counter follows wrong event");

    a_inc_sel_hi: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        cfg0[F_EN_HI] |-> inc_hi[0] == evt_i[cfg0[F_SEL_HI +: F_SEL_W]])
        else $error("high counter follows wrong event");

    a_cnt_wr_lo: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        lo_wr[0] |=> c0_lo == $past(pwdata_i))
        else $error("low counter write not stored");

    a_cnt_wr_hi: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        hi_wr[0] |=> c0_hi == $past(pwdata_i))
        else $error("high counter write not stored");

    c_fold_nonzero: cover property (@(posedge mclk_i) disable iff (!arst_n_i)
        slot == 3'h0 && a0_lo != 4'h0);

    c_overflow: cover property (@(posedge mclk_i) disable iff (!arst_n_i)
        ovf_lo[0] ##1 trap_req_o[0]);

    c_apb_read: cover property (@(posedge mclk_i) disable iff (!arst_n_i)
        psel_i && !penable_i && !pwrite_i ##1 psel_i && penable_i);

    c_err: cover property (@(posedge mclk_i) disable iff (!arst_n_i)
        pslverr_o);

    c_wrap_hi: cover property (@(posedge mclk_i) disable iff (!arst_n_i)
        ovf_hi[0] ##1 cfg0[F_OVF_HI]);

endmodule

`default_nettype wire

// *** bench/tpc_evt_src.sv ***
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// core event source: repeats one event mask for n cycles
// ------------------------------------------------------------
module tpc_evt_src (
    // clock and reset
    input wire logic mclk_i,
    input wire logic arst_n_i,
    // request
    input wire logic go_i,
    input wire logic [63:0] mask_i,
    input wire logic [7:0] n_i,
    // event pulses
    output logic [63:0] evt_o,
    output logic busy_o
);
    logic [7:0] left_q;
    logic [7:0] left_d;
    logic [63:0] mask_q;
    logic [63:0] mask_d;

    always_comb begin
        left_d = left_q;
        mask_d = mask_q;
        if (go_i) begin
            left_d = n_i;
            mask_d = mask_i;
        end else if (left_q != 8'h00) begin
            left_d = left_q - 8'h01;
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            left_q <= 8'h00;
            mask_q <= 64'h0;
        end else begin
            left_q <= left_d;
            mask_q <= mask_d;
        end
    end

    // pulses stay low outside a burst
    assign evt_o = (left_q != 8'h00) ? mask_q : 64'h0;
    assign busy_o = go_i | (left_q != 8'h00);
endmodule

`default_nettype wire

// *** bench/tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic mclk_i, arst_n_i, psel, penable, pwrite, go;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, wake, busy, er;
    logic [7:0] trap, n;
    logic [63:0] evt, mask;
    int fail_count, n_compared, k, j;
    // ------------------------------------------------------------
    // ordinary cases: address, write data, read back, error
    // ------------------------------------------------------------
    logic [11:0] r_a [6] = '{12'h000, 12'h074, 12'h038, 12'h054, 12'h01c, 12'h080};
    logic [31:0] r_d [6] = '{32'hfffff000, 32'h12345678, 32'h0badf00d, 32'hffffffff,
                             32'hffffffff, 32'h5a5a5a5a};
    logic [31:0] r_e [6] = '{32'h0, 32'h12345678, 32'h0badf00d, 32'hffffffff, 32'h0, 32'h0};
    logic r_x [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};

    tpc_top i_dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready),
        .prdata_o(prdata), .pslverr_o(pslverr), .evt_i(evt), .trap_req_o(trap),
        .wake_o(wake));

    tpc_evt_src i_src (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .go_i(go), .mask_i(mask),
        .n_i(n), .evt_o(evt), .busy_o(busy));

    initial begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge mclk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk_i);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge mclk_i);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            fail_count++;
            wrap_up();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] e, input logic x);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
        chk({31'h0, er}, {31'h0, x});
    endtask

    task automatic evts(input logic [63:0] m, input logic [7:0] c);
        int i;
        @(posedge mclk_i);
        go <= 1'b1;
        mask <= m;
        n <= c;
        @(posedge mclk_i);
        go <= 1'b0;
        for (i = 0; i < 300; i++) begin
            @(posedge mclk_i);
            if (busy === 1'b0) break;
        end
        if (i == 300) begin
            fail_count++;
            wrap_up();
        end
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        arst_n_i = 1'b0;
        {psel, penable, pwrite, go} = 4'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        mask = 64'h0;
        n = 8'h00;
        fail_count = 0;
        n_compared = 0;
        repeat (8) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        chk({31'h0, wake}, 32'h0);
        for (k = 0; k < 8; k++) begin
            for (j = 0; j < 3; j++) begin
                rchk(12'(k * 16 + j * 4), 32'h0, 1'b0);
            end
        end
        for (k = 0; k < 6; k++) begin
            apb(1'b1, r_a[k], r_d[k]);
            rchk(r_a[k], r_e[k], r_x[k]);
        end
        // thread 2: low counts event 5, high counts event 1
        apb(1'b1, 12'h020, 32'h000000cd);
        @(posedge mclk_i);
        chk({31'h0, wake}, 32'h1);
        evts(64'h0000_0000_0023_0000, 8'd12);
        evts(64'h0000_0000_0020_0000, 8'd8);
        repeat (20) @(posedge mclk_i);
        rchk(12'h024, 32'd20, 1'b0);
        rchk(12'h028, 32'd12, 1'b0);
        // thread 0: both counters wrap past the top, overflow and trap
        apb(1'b1, 12'h000, 32'h000003c0);
        apb(1'b1, 12'h004, 32'hffffffff);
        apb(1'b1, 12'h008, 32'hfffffffd);
        evts(64'h0000_0000_0000_0001, 8'd5);
        repeat (20) @(posedge mclk_i);
        rchk(12'h004, 32'h00000004, 1'b0);
        rchk(12'h008, 32'h00000002, 1'b0);
        rchk(12'h000, 32'h00000fc0, 1'b0);
        chk({24'h0, trap}, 32'h01);
        apb(1'b1, 12'h000, 32'h000003c0);
        repeat (3) @(posedge mclk_i);
        chk({24'h0, trap}, 32'h0);
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b1, 12'h020, 32'h0);
        repeat (3) @(posedge mclk_i);
        chk({31'h0, wake}, 32'h0);
        // reset in mid-run clears the counters
        arst_n_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        rchk(12'h024, 32'h0, 1'b0);
        wrap_up();
    end
endmodule

`default_nettype wire
